// *** tae_pkg.sv ***
// constants and types, including the pin synchroniser state, for the timer/event counter channel
`default_nettype none
package tae_pkg;
    localparam int CNT_W = 16;                        // counter width
    localparam logic [15:0] ALL_ONES = 16'hffff;      // read value at underflow reload
    localparam logic [15:0] ALL_ZERO = 16'h0000;      // read value at overflow reload
    localparam logic [15:0] COUNT_RST = 16'h0000;     // counter and latch after reset
    localparam logic [15:0] ONE = 16'h0001;           // count step
    localparam logic [3:0] PRESCALE_LAST = 4'h7;      // internal count source = clock / 8
    localparam logic [3:0] PRESCALE_RST = 4'h0;       // prescaler after reset
    localparam logic [1:0] SYNC_RST = 2'h0;           // synchroniser stages after reset

    // run state, one-hot
    typedef enum logic [1:0] {
        TAE_HALTED = 2'b01,
        TAE_RUNNING = 2'b10
    } tae_run_t;

    // static mode selection, same clock domain as the counter
    typedef struct packed {
        logic eventMode;   // 1: count pin pulses, 0: count internal source
        logic quadMode;    // two-phase input on both channel pins
        logic freeRun;     // no reload on wrap in event mode
        logic countUp;     // single-phase event direction
        logic fallEdge;    // single-phase event edge select
        logic outEnable;   // toggle output pin on each wrap, except in two-phase mode
    } tae_mode_t;

    // state of the channel, all but the pin synchroniser stages
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] reload;
        tae_run_t run;
        logic [3:0] prescale;
        logic [15:0] readData;
        logic readValid;
        logic pulseOut;
        logic pulseOutEn;
        logic reloadEvent;
        logic prevA;
    } tae_state_t;

    // synchroniser state
    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
    } tae_sync_t;
endpackage : tae_pkg
`default_nettype wire

// *** tae_pin_sync.sv ***
// two-flop synchroniser for the two channel pins
`timescale 1ns/100ps
`default_nettype none
module tae_pin_sync (
    input wire logic clock,
    input wire logic reset,
    input wire logic [1:0] pinIn,
    output logic [1:0] pinOut
);
    tae_pkg::tae_sync_t st_r;   // stage state
    tae_pkg::tae_sync_t st_nxt; // next stage state

    // first stage only feeds the second
    always_comb
    begin
        st_nxt.s1 = pinIn;
        st_nxt.s2 = st_r.s1;
    end

    // stage registers
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            st_r <= {tae_pkg::SYNC_RST, tae_pkg::SYNC_RST};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign pinOut = st_r.s2;
endmodule : tae_pin_sync
`default_nettype wire

// *** tae_timer_event_counter.sv ***
// 16-bit timer / event counter channel with reload latch and live read
`timescale 1ns/100ps
`default_nettype none
module tae_timer_event_counter (
    input wire logic clock,
    input wire logic reset,
    input wire tae_pkg::tae_mode_t mode,
    input wire logic timerWrite,
    input wire logic [15:0] timerWriteData,
    input wire logic timerRead,
    output logic [15:0] readData,
    output logic readValid,
    input wire logic startWrite,
    input wire logic startValue,
    output logic countStart,
    input wire logic channelPulseInput,
    input wire logic channelPulseOutputIn,
    output logic channelPulseOutput,
    output logic channelPulseOutputEn,
    output logic reloadEvent
);
    tae_pkg::tae_state_t st_r;   // registered state
    tae_pkg::tae_state_t st_nxt; // next state
    logic [1:0] pinSync;         // synchronised {output pin, input pin}
    logic pinA;                  // synced input pin
    logic pinB;                  // synced output pin, second phase
    logic running;               // counting in progress
    logic tick;                  // internal count source pulse
    logic step;                  // one count this cycle
    logic up;                    // count direction
    logic underflow;             // down count past zero
    logic overflow;              // up count past all ones
    logic reloadNow;             // counter takes the latch this cycle

    // add or subtract one, wrapping at 16 bits
    function automatic logic [15:0] stepValue(input logic [15:0] value, input logic dirUp);
        logic [15:0] result;
        result = dirUp ? value + tae_pkg::ONE : value - tae_pkg::ONE;
        return result;
    endfunction : stepValue

    // pins are asynchronous, so both pass two flops
    tae_pin_sync pinSyncInst (
        .clock(clock),
        .reset(reset),
        .pinIn({channelPulseOutputIn, channelPulseInput}),
        .pinOut(pinSync)
    );
    assign pinA = pinSync[0];
    assign pinB = pinSync[1];
    assign running = (st_r.run == tae_pkg::TAE_RUNNING);

    // count source and wrap detection
    always_comb
    begin
        tick = running && !mode.eventMode && (st_r.prescale == tae_pkg::PRESCALE_LAST);
        step = 1'b0;
        up = 1'b0;
        if (running)
        begin
            if (!mode.eventMode)
            begin
                // timer mode always counts down
                step = tick;
            end
            else if (mode.quadMode)
            begin
                // phase b level at a's rising edge gives direction; relies on
                // the source keeping the phases apart
                step = pinA && !st_r.prevA;
                up = !pinB;
            end
            else
            begin
                // single phase, edge chosen by mode
                step = mode.fallEdge ? (!pinA && st_r.prevA) : (pinA && !st_r.prevA);
                up = mode.countUp;
            end
        end
        underflow = step && !up && (st_r.count == tae_pkg::ALL_ZERO);
        overflow = step && up && (st_r.count == tae_pkg::ALL_ONES);
        // free run only exists in event mode; timer mode always reloads
        reloadNow = (underflow || overflow) && !(mode.eventMode && mode.freeRun);
    end

    // next state
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.prevA = pinA;
        st_nxt.readValid = timerRead;
        st_nxt.reloadEvent = reloadNow;
        // output pin is an input while two-phase counting
        st_nxt.pulseOutEn = mode.outEnable && !mode.quadMode;

        // start flag from software; reset leaves it halted
        if (startWrite)
        begin
            st_nxt.run = startValue ? tae_pkg::TAE_RUNNING : tae_pkg::TAE_HALTED;
        end

        // prescaler only runs while counting in timer mode
        if (running && !mode.eventMode)
        begin
            st_nxt.prescale = tick ? tae_pkg::PRESCALE_RST : st_r.prescale + 4'h1;
        end
        else
        begin
            st_nxt.prescale = tae_pkg::PRESCALE_RST;
        end

        // counting
        if (reloadNow)
        begin
            st_nxt.count = st_r.reload;
        end
        else if (step)
        begin
            st_nxt.count = stepValue(st_r.count, up);
        end

        // each wrap toggles the output pin while its drive is enabled
        if ((underflow || overflow) && st_nxt.pulseOutEn)
        begin
            st_nxt.pulseOut = !st_r.pulseOut;
        end

        // writes: latch always, counter only while halted; a free-run stop
        // leaves the wrapped count, hence software rewrites before restart
        if (timerWrite)
        begin
            st_nxt.reload = timerWriteData;
            if (!running)
            begin
                st_nxt.count = timerWriteData;
            end
        end

        // read captures live count, or the fixed value at the reload moment
        if (timerRead)
        begin
            if (reloadNow && underflow)
            begin
                st_nxt.readData = tae_pkg::ALL_ONES;
            end
            else if (reloadNow)
            begin
                st_nxt.readData = tae_pkg::ALL_ZERO;
            end
            else
            begin
                st_nxt.readData = st_r.count;
            end
        end
    end

    // single state register
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            st_r.count <= tae_pkg::COUNT_RST;
            st_r.reload <= tae_pkg::COUNT_RST;
            st_r.run <= tae_pkg::TAE_HALTED;
            st_r.prescale <= tae_pkg::PRESCALE_RST;
            st_r.readData <= tae_pkg::COUNT_RST;
            st_r.readValid <= 1'b0;
            st_r.pulseOut <= 1'b0;
            st_r.pulseOutEn <= 1'b0;
            st_r.reloadEvent <= 1'b0;
            st_r.prevA <= 1'b0;
        end
        else
        begin
            case (st_nxt.run)
                tae_pkg::TAE_HALTED: st_r <= st_nxt;
                tae_pkg::TAE_RUNNING: st_r <= st_nxt;
                default:
                begin
                    // illegal run code falls back to halted
                    st_r <= st_nxt;
                    st_r.run <= tae_pkg::TAE_HALTED;
                end
            endcase
        end
    end

    assign readData = st_r.readData;
    assign readValid = st_r.readValid;
    assign countStart = st_r.run[1]; // one-hot running bit, straight from the flop
    assign channelPulseOutput = st_r.pulseOut;
    assign channelPulseOutputEn = st_r.pulseOutEn;
    assign reloadEvent = st_r.reloadEvent;

    // checks
    property p_startLow;
        @(posedge clock) disable iff (reset) $past(reset) |-> !countStart;
    endproperty
    a_startLow: assert property (p_startLow) else $error("start flag set after reset");

    property p_liveRead;
        @(posedge clock) disable iff (reset)
            (timerRead && !reloadNow) |=> (readData == $past(st_r.count)) && readValid;
    endproperty
    a_liveRead: assert property (p_liveRead) else $error("read not live count");

    property p_underRead;
        @(posedge clock) disable iff (reset)
            (timerRead && reloadNow && underflow) |=> readData == 16'hffff;
    endproperty
    a_underRead: assert property (p_underRead) else $error("underflow read not ones");

    property p_overRead;
        @(posedge clock) disable iff (reset)
            (timerRead && reloadNow && overflow) |=> readData == 16'h0000;
    endproperty
    a_overRead: assert property (p_overRead) else $error("overflow read not zero");

    property p_haltedReadBack;
        @(posedge clock) disable iff (reset)
            (!running && timerWrite && !startWrite) ##1 (timerRead && !running)
            |=> readData == $past(timerWriteData, 2);
    endproperty
    a_haltedReadBack: assert property (p_haltedReadBack) else $error("halted readback wrong");

    property p_haltedLoad;
        @(posedge clock) disable iff (reset)
            (!running && timerWrite) |=>
            (st_r.count == $past(timerWriteData)) && (st_r.reload == $past(timerWriteData));
    endproperty
    a_haltedLoad: assert property (p_haltedLoad) else $error("halted write not loaded");

    property p_runWriteLatch;
        @(posedge clock) disable iff (reset)
            (running && timerWrite && !reloadNow && !step) |=>
            (st_r.reload == $past(timerWriteData)) && $stable(st_r.count);
    endproperty
    a_runWriteLatch: assert property (p_runWriteLatch) else $error("running write hit counter");

    property p_reloadTakes;
        @(posedge clock) disable iff (reset)
            (reloadNow && !timerWrite) |=> reloadEvent && (st_r.count == $past(st_r.reload));
    endproperty
    a_reloadTakes: assert property (p_reloadTakes) else $error("reload not taken");
endmodule : tae_timer_event_counter
`default_nettype wire

// *** tae_pulse_src.sv ***
// external pulse source model driving the two channel pins
`timescale 1ns/100ps
`default_nettype none
module tae_pulse_src #(
    parameter int GAP = 4
) (
    input wire logic clock,
    output logic pinA,
    output logic pinB
);
    // both pins idle low
    initial
    begin
        pinA = 1'b0;
        pinB = 1'b0;
    end
    // one pulse on A; B level sets quad direction
    // each edge inside one pulse is GAP clocks from the next, so the phase gap always holds
    // the leading edge keeps pinB from changing twice in one clock cycle
    // when two pulses are sent back to back
    task automatic step(input logic dn);
        @(posedge clock);
        #2 pinB = dn;
        repeat (GAP) @(posedge clock);
        #2 pinA = 1'b1;
        repeat (GAP) @(posedge clock);
        #2 pinA = 1'b0;
        repeat (GAP) @(posedge clock);
        #2 pinB = 1'b0;
    endtask : step
endmodule : tae_pulse_src
`default_nettype wire

// *** tb_timer_a_timer_event_counter.sv ***
// self-checking bench for the timer / event counter channel
`timescale 1ns/100ps
`default_nettype none
module tb_timer_a_timer_event_counter;
    // one table row: mode, halted value, quad direction, read at wrap
    typedef struct packed {
        tae_pkg::tae_mode_t mode;
        logic [15:0] wval;
        logic dn;
        logic [15:0] wrap;
    } tae_row_t;
    logic clock = 1'b0;
    logic reset = 1'b1;
    tae_pkg::tae_mode_t mode = '0;
    logic timerWrite = 1'b0;
    logic [15:0] timerWriteData = 16'h0000;
    logic timerRead = 1'b0;
    logic startWrite = 1'b0;
    logic startValue = 1'b0;
    logic [15:0] readData;
    logic readValid, countStart, pinOut, pinOutEn, reloadEvent, pinA, pinB;
    // output pin level: design drives it only when enabled
    wire pinWire = pinOutEn ? pinOut : pinB;
    int miscompares = 0;
    int numChecks = 0;
    // event rows: single up/down, quad up/down, pin output on, quad with output asked
    tae_row_t rows [6] = '{
        '{6'b100100, 16'hfffe, 1'b0, 16'h0000},
        '{6'b100010, 16'h0001, 1'b0, 16'hffff},
        '{6'b110000, 16'hfffe, 1'b0, 16'h0000},
        '{6'b110000, 16'h0001, 1'b1, 16'hffff},
        '{6'b100101, 16'hfffe, 1'b0, 16'h0000},
        '{6'b110001, 16'h0001, 1'b1, 16'hffff}};

    always #12.5 clock = ~clock;

    tae_timer_event_counter dut (
        .clock(clock), .reset(reset), .mode(mode),
        .timerWrite(timerWrite), .timerWriteData(timerWriteData),
        .timerRead(timerRead), .readData(readData), .readValid(readValid),
        .startWrite(startWrite), .startValue(startValue), .countStart(countStart),
        .channelPulseInput(pinA), .channelPulseOutputIn(pinWire),
        .channelPulseOutput(pinOut), .channelPulseOutputEn(pinOutEn),
        .reloadEvent(reloadEvent));
    tae_pulse_src src (.clock(clock), .pinA(pinA), .pinB(pinB));

    task automatic print_verdict;
        if (miscompares == 0 && numChecks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    // compare and count
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        numChecks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // inputs always change 2 ns after the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask : cyc
    task automatic wr(input logic [15:0] d);
        timerWrite = 1'b1;
        timerWriteData = d;
        cyc(1);
        timerWrite = 1'b0;
    endtask : wr
    task automatic start(input logic v);
        startWrite = 1'b1;
        startValue = v;
        cyc(1);
        startWrite = 1'b0;
        check({15'h0, countStart}, {15'h0, v});
    endtask : start
    task automatic rd(input logic [15:0] exp);
        timerRead = 1'b1;
        cyc(1);
        timerRead = 1'b0;
        check({15'h0, readValid}, 16'h0001);
        check(readData, exp);
    endtask : rd
    // reads every cycle; the read taken at the wrap shows when reloadEvent rises
    task automatic wait_wrap(input logic [15:0] exp);
        int k;
        timerRead = 1'b1;
        for (k = 0; k < 300 && reloadEvent !== 1'b1; k++)
            cyc(1);
        if (k == 300)
        begin
            miscompares++;
            print_verdict();
        end
        else
            check(readData, exp);
    endtask : wait_wrap

    initial
    begin
        cyc(16);
        reset = 1'b0;
        // event counter rows, counter rewritten after every stop
        foreach (rows[i])
        begin
            start(1'b0);
            mode = rows[i].mode;
            wr(rows[i].wval);
            start(1'b1);
            fork
                repeat (2) src.step(rows[i].dn);
                wait_wrap(rows[i].wrap);
            join
            timerRead = 1'b0;
        end
        // one wrap toggled the pin; two-phase mode keeps the pin undriven
        check({14'h0, pinOut, pinOutEn}, 16'h0002);
        // timer mode: wrap read, live reads, write while running
        start(1'b0);
        mode = 6'b000001;
        wr(16'h0002);
        start(1'b1);
        wait_wrap(16'hffff);
        check({15'h0, pinOut}, 16'h0000);
        cyc(1);
        check(readData, 16'h0002);
        cyc(8);
        check(readData, 16'h0001);
        wr(16'h0005);
        check(readData, 16'h0001);
        check({15'h0, pinOutEn}, 16'h0001);
        wait_wrap(16'hffff);
        check({15'h0, pinOut}, 16'h0001);
        cyc(1);
        check(readData, 16'h0005);
        timerRead = 1'b0;
        // free run: wraps to zero, no reload from latch
        start(1'b0);
        mode = 6'b101100;
        wr(16'hffff);
        start(1'b1);
        src.step(1'b0);
        rd(16'h0000);
        // reset in mid-run clears flag and read path
        reset = 1'b1;
        cyc(2);
        reset = 1'b0;
        check({14'h0, countStart, readValid}, 16'h0000);
        check(readData, 16'h0000);
        // halted write then read-back at the boundaries
        mode = 6'b000000;
        wr(16'hffff);
        rd(16'hffff);
        wr(16'h0000);
        rd(16'h0000);
        wr(16'ha5a5);
        rd(16'ha5a5);
        start(1'b1);
        rd(16'ha5a5);
        print_verdict();
    end
endmodule : tb_timer_a_timer_event_counter
`default_nettype wire
